/* File: pkg/dsb_pkg.sv */
// Shared constants, register map and types of the decrement, skip and branch execution block.
package dsb_pkg;
	localparam int AXI_AW = 8;
	localparam int AXI_DW = 32;
	localparam int PC_W = 21;
	localparam int MEM_AW = 12;
	localparam logic [AXI_AW-1:0] OFS_CTRL = 8'h00;
	localparam logic [AXI_AW-1:0] OFS_INSTR = 8'h04;
	localparam logic [AXI_AW-1:0] OFS_STATUS = 8'h08;
	localparam logic [AXI_AW-1:0] OFS_PC = 8'h0C;
	localparam logic [AXI_AW-1:0] OFS_WREG = 8'h10;
	localparam logic [AXI_AW-1:0] OFS_BSR = 8'h14;
	localparam logic [AXI_AW-1:0] OFS_FLAGS = 8'h18;
	localparam logic [AXI_AW-1:0] OFS_FSR2 = 8'h1C;
	localparam logic [AXI_AW-1:0] OFS_DADDR = 8'h20;
	localparam logic [AXI_AW-1:0] OFS_DATA = 8'h24;
	localparam int CTRL_EXT_BIT = 0;
	localparam int FLAGS_CARRY_BIT = 0;
	localparam int INSTR_TWO_WORD_BIT = 16;
	localparam logic [7:0] OPC_BRANCH_CARRY = 8'hE2;
	localparam logic [5:0] OPC_DEC_SKIP_ZERO = 6'h0B;
	localparam logic [5:0] OPC_DEC_SKIP_NONZERO = 6'h13;
	localparam logic [7:0] INDEX_LIMIT = 8'h5F;
	localparam logic [3:0] ACCESS_HIGH_BANK = 4'hF;
	localparam logic [1:0] Q_FIRST = 2'h0;
	localparam logic [1:0] Q_READ = 2'h1;
	localparam logic [1:0] Q_PROCESS = 2'h2;
	localparam logic [1:0] Q_WRITE = 2'h3;
	localparam logic [PC_W-1:0] PC_STEP = 21'h000002;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	typedef enum logic [1:0] {
		ST_IDLE = 2'h0,
		ST_EXEC = 2'h1,
		ST_IDLE_CYC = 2'h2
	} dsb_state_e;
	typedef struct packed {
		logic [5:0] op;
		logic dest;
		logic acc;
		logic [7:0] file;
	} dsb_instr_s;
	typedef struct packed {
		logic [3:0] cycles;
		logic illegal;
		logic taken;
		logic skip;
		logic busy;
	} dsb_status_s;
endpackage

/* File: design/dsb_mem.sv */
// Single-port file register memory with a registered read port.
`timescale 1ns/10ps
`default_nettype none
module dsb_mem #(
	parameter int AW = 12,
	parameter int DW = 8
) (
	input wire logic clk,
	input wire logic we,
	input wire logic [AW-1:0] addr,
	input wire logic [DW-1:0] wdata,
	output var logic [DW-1:0] rdata
);
	logic [DW-1:0] mem [0:(1<<AW)-1];

	always_ff @(posedge clk)
	begin
		if (we)
		begin
			mem[addr] <= wdata;
		end
		rdata <= mem[addr];
	end
endmodule // dsb_mem
`default_nettype wire

/* File: design/dsb_exec.sv */
// Execution logic for carry branch and decrement-and-skip instructions with an AXI4-Lite slave.
//
// Decided for this implementation: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
`default_nettype none
module dsb_exec
	import dsb_pkg::*;
#(
	parameter int MEM_ADDR_W = MEM_AW
) (
	input wire logic CLK,
	input wire logic NRST,
	input wire logic [dsb_pkg::AXI_AW-1:0] S_AXI_AWADDR,
	input wire logic S_AXI_AWVALID,
	output var logic S_AXI_AWREADY,
	input wire logic [dsb_pkg::AXI_DW-1:0] S_AXI_WDATA,
	input wire logic [3:0] S_AXI_WSTRB,
	input wire logic S_AXI_WVALID,
	output var logic S_AXI_WREADY,
	output var logic [1:0] S_AXI_BRESP,
	output var logic S_AXI_BVALID,
	input wire logic S_AXI_BREADY,
	input wire logic [dsb_pkg::AXI_AW-1:0] S_AXI_ARADDR,
	input wire logic S_AXI_ARVALID,
	output var logic S_AXI_ARREADY,
	output var logic [dsb_pkg::AXI_DW-1:0] S_AXI_RDATA,
	output var logic [1:0] S_AXI_RRESP,
	output var logic S_AXI_RVALID,
	input wire logic S_AXI_RREADY
);
	logic [AXI_AW-1:0] aw_addr_reg;
	logic [AXI_DW-1:0] w_data_reg;
	logic [3:0] w_strb_reg;
	logic [AXI_DW-1:0] wmask;
	logic [AXI_DW-1:0] wval;
	logic do_write;
	logic wr_instr;
	logic ext_en_reg;
	logic carry_reg;
	logic [PC_W-1:0] pc_reg;
	logic [PC_W-1:0] pc_next;
	logic [7:0] wreg_reg;
	logic [3:0] bsr_reg;
	logic [MEM_ADDR_W-1:0] fsr2_reg;
	logic [MEM_ADDR_W-1:0] daddr_reg;
	dsb_instr_s instr_reg;
	logic two_word_reg;
	dsb_state_e state_reg;
	logic [1:0] q_reg;
	logic q_last;
	logic [1:0] nop_left_reg;
	logic [1:0] nop_count;
	dsb_status_s status_reg;
	logic [7:0] dec_reg;
	logic is_branch;
	logic is_dsz;
	logic is_dsnz;
	logic skip;
	logic [MEM_ADDR_W-1:0] exec_addr;
	logic [MEM_ADDR_W-1:0] mem_addr;
	logic mem_we;
	logic [7:0] mem_wdata;
	logic [7:0] mem_rdata;
	logic [AXI_DW-1:0] rd_val;
	logic rd_err;
	logic wr_err;

	// Write side: address and data are taken in either order and held until the response is taken.
	assign do_write = !S_AXI_AWREADY && !S_AXI_WREADY && !S_AXI_BVALID;

	genvar b;
	generate
		for (b = 0; b < 4; b++)
		begin : g_lane
			assign wmask[8*b+7:8*b] = {8{w_strb_reg[b]}};
		end
	endgenerate
	assign wval = w_data_reg & wmask;
	assign wr_instr = do_write && (aw_addr_reg == OFS_INSTR) && (state_reg == ST_IDLE);

	always_comb
	begin
		wr_err = 1'h0;
		if (aw_addr_reg == OFS_CTRL || aw_addr_reg == OFS_INSTR || aw_addr_reg == OFS_PC)
		begin
			wr_err = 1'h0;
		end
		else if (aw_addr_reg == OFS_WREG || aw_addr_reg == OFS_BSR || aw_addr_reg == OFS_FLAGS)
		begin
			wr_err = 1'h0;
		end
		else if (aw_addr_reg == OFS_FSR2 || aw_addr_reg == OFS_DADDR || aw_addr_reg == OFS_DATA)
		begin
			wr_err = 1'h0;
		end
		else if (aw_addr_reg == OFS_STATUS)
		begin
			wr_err = 1'h0;
		end
		else
		begin
			wr_err = 1'h1;
		end
	end

	always_ff @(posedge CLK)
	begin
		if (!NRST)
		begin
			S_AXI_AWREADY <= 1'h1;
			S_AXI_WREADY <= 1'h1;
			S_AXI_BVALID <= 1'h0;
			S_AXI_BRESP <= RESP_OKAY;
			aw_addr_reg <= 8'h00;
			w_data_reg <= 32'h00000000;
			w_strb_reg <= 4'h0;
		end
		else
		begin
			if (S_AXI_AWVALID && S_AXI_AWREADY)
			begin
				S_AXI_AWREADY <= 1'h0;
				aw_addr_reg <= S_AXI_AWADDR;
			end
			if (S_AXI_WVALID && S_AXI_WREADY)
			begin
				S_AXI_WREADY <= 1'h0;
				w_data_reg <= S_AXI_WDATA;
				w_strb_reg <= S_AXI_WSTRB;
			end
			if (do_write)
			begin
				S_AXI_BVALID <= 1'h1;
				S_AXI_BRESP <= wr_err ? RESP_SLVERR : RESP_OKAY;
			end
			else if (S_AXI_BVALID && S_AXI_BREADY)
			begin
				S_AXI_BVALID <= 1'h0;
				S_AXI_AWREADY <= 1'h1;
				S_AXI_WREADY <= 1'h1;
			end
		end
	end

	// Software-owned configuration and machine state; strobed byte lanes merge with the old value.
	always_ff @(posedge CLK)
	begin
		if (!NRST)
		begin
			ext_en_reg <= 1'h0;
			carry_reg <= 1'h0;
			bsr_reg <= 4'h0;
			fsr2_reg <= '0;
			daddr_reg <= '0;
		end
		else if (do_write)
		begin
			if (aw_addr_reg == OFS_CTRL && w_strb_reg[0])
			begin
				ext_en_reg <= wval[CTRL_EXT_BIT];
			end
			else if (aw_addr_reg == OFS_FLAGS && w_strb_reg[0])
			begin
				carry_reg <= wval[FLAGS_CARRY_BIT];
			end
			else if (aw_addr_reg == OFS_BSR && w_strb_reg[0])
			begin
				bsr_reg <= wval[3:0];
			end
			else if (aw_addr_reg == OFS_FSR2)
			begin
				fsr2_reg <= (fsr2_reg & ~wmask[MEM_ADDR_W-1:0]) | wval[MEM_ADDR_W-1:0];
			end
			else if (aw_addr_reg == OFS_DADDR)
			begin
				daddr_reg <= (daddr_reg & ~wmask[MEM_ADDR_W-1:0]) | wval[MEM_ADDR_W-1:0];
			end
		end
	end

	// Instruction decode and operand address.
	assign is_branch = ({instr_reg.op, instr_reg.dest, instr_reg.acc} == OPC_BRANCH_CARRY);
	assign is_dsz = (instr_reg.op == OPC_DEC_SKIP_ZERO);
	assign is_dsnz = (instr_reg.op == OPC_DEC_SKIP_NONZERO);
	assign skip = (is_dsz && dec_reg == 8'h00) || (is_dsnz && dec_reg != 8'h00);

	always_comb
	begin
		exec_addr = {bsr_reg, instr_reg.file};
		if (!instr_reg.acc && ext_en_reg && instr_reg.file <= INDEX_LIMIT)
		begin
			exec_addr = fsr2_reg + {4'h0, instr_reg.file};
		end
		else if (!instr_reg.acc)
		begin
			exec_addr = instr_reg.file[7] ? {ACCESS_HIGH_BANK, instr_reg.file}
				: {4'h0, instr_reg.file};
		end
	end

	always_comb
	begin
		nop_count = 2'h0;
		pc_next = pc_reg + PC_STEP;
		if (is_branch && carry_reg)
		begin
			pc_next = pc_reg + PC_STEP + {{(PC_W-9){instr_reg.file[7]}}, instr_reg.file, 1'h0};
			nop_count = 2'h1;
		end
		else if (skip && two_word_reg)
		begin
			pc_next = pc_reg + PC_STEP + PC_STEP + PC_STEP;
			nop_count = 2'h2;
		end
		else if (skip)
		begin
			pc_next = pc_reg + PC_STEP + PC_STEP;
			nop_count = 2'h1;
		end
	end

	// The core runs four phases per instruction cycle; q_last is the cycle-end enable pulse.
	assign q_last = (q_reg == Q_WRITE);

	always_ff @(posedge CLK)
	begin
		if (!NRST || state_reg == ST_IDLE)
		begin
			q_reg <= Q_FIRST;
		end
		else
		begin
			q_reg <= q_reg + 2'h1;
		end
	end

	always_ff @(posedge CLK)
	begin
		if (!NRST)
		begin
			state_reg <= ST_IDLE;
			nop_left_reg <= 2'h0;
			instr_reg <= '0;
			two_word_reg <= 1'h0;
		end
		else
		begin
			case (state_reg)
				ST_IDLE:
				begin
					if (wr_instr)
					begin
						instr_reg <= wval[15:0];
						two_word_reg <= wval[INSTR_TWO_WORD_BIT];
						state_reg <= ST_EXEC;
					end
				end
				ST_EXEC:
				begin
					if (q_last)
					begin
						nop_left_reg <= nop_count;
						state_reg <= (nop_count == 2'h0) ? ST_IDLE : ST_IDLE_CYC;
					end
				end
				ST_IDLE_CYC:
				begin
					if (q_last)
					begin
						nop_left_reg <= nop_left_reg - 2'h1;
						if (nop_left_reg == 2'h1)
						begin
							state_reg <= ST_IDLE;
						end
					end
				end
				default:
				begin
					state_reg <= ST_IDLE;
				end
			endcase
		end
	end

	// Process phase: the decremented value is formed from the operand read in the read phase.
	always_ff @(posedge CLK)
	begin
		if (!NRST)
		begin
			dec_reg <= 8'h00;
		end
		else if (state_reg == ST_EXEC && q_reg == Q_PROCESS)
		begin
			dec_reg <= mem_rdata - 8'h01;
		end
	end

	// Writeback phase. Carry is never written here, only by software.
	always_ff @(posedge CLK)
	begin
		if (!NRST)
		begin
			pc_reg <= '0;
			wreg_reg <= 8'h00;
		end
		else if (state_reg == ST_EXEC && q_last)
		begin
			pc_reg <= pc_next;
			if ((is_dsz || is_dsnz) && !instr_reg.dest)
			begin
				wreg_reg <= dec_reg;
			end
		end
		else if (do_write && state_reg == ST_IDLE && aw_addr_reg == OFS_PC)
		begin
			pc_reg <= (pc_reg & ~wmask[PC_W-1:0]) | wval[PC_W-1:0];
		end
		else if (do_write && state_reg == ST_IDLE && aw_addr_reg == OFS_WREG && w_strb_reg[0])
		begin
			wreg_reg <= wval[7:0];
		end
	end

	always_ff @(posedge CLK)
	begin
		if (!NRST)
		begin
			status_reg <= '0;
		end
		else if (wr_instr)
		begin
			status_reg <= '0;
			status_reg.busy <= 1'h1;
		end
		else if (state_reg != ST_IDLE && q_last)
		begin
			status_reg.cycles <= status_reg.cycles + 4'h1;
			if (state_reg == ST_EXEC)
			begin
				status_reg.skip <= skip;
				status_reg.taken <= is_branch && carry_reg;
				status_reg.illegal <= !(is_branch || is_dsz || is_dsnz);
				status_reg.busy <= (nop_count != 2'h0);
			end
			else
			begin
				status_reg.busy <= (nop_left_reg != 2'h1);
			end
		end
	end

	// Bus access to the file memory is ignored while an instruction owns the port: writes are dropped and reads return zero, both with OKAY.
	assign mem_addr = (state_reg == ST_IDLE) ? daddr_reg : exec_addr;
	assign mem_we = (state_reg == ST_EXEC && q_last && (is_dsz || is_dsnz) && instr_reg.dest)
		|| (do_write && state_reg == ST_IDLE && aw_addr_reg == OFS_DATA && w_strb_reg[0]);
	assign mem_wdata = (state_reg == ST_IDLE) ? wval[7:0] : dec_reg;

	dsb_mem #(
		.AW(MEM_ADDR_W),
		.DW(8)
	) u_mem (
		.clk(CLK),
		.we(mem_we),
		.addr(mem_addr),
		.wdata(mem_wdata),
		.rdata(mem_rdata)
	);

	always_comb
	begin
		rd_val = 32'h00000000;
		rd_err = 1'h0;
		if (S_AXI_ARADDR == OFS_CTRL)
		begin
			rd_val[CTRL_EXT_BIT] = ext_en_reg;
		end
		else if (S_AXI_ARADDR == OFS_INSTR)
		begin
			rd_val[INSTR_TWO_WORD_BIT:0] = {two_word_reg, instr_reg};
		end
		else if (S_AXI_ARADDR == OFS_STATUS)
		begin
			rd_val[7:0] = status_reg;
		end
		else if (S_AXI_ARADDR == OFS_PC)
		begin
			rd_val[PC_W-1:0] = pc_reg;
		end
		else if (S_AXI_ARADDR == OFS_WREG)
		begin
			rd_val[7:0] = wreg_reg;
		end
		else if (S_AXI_ARADDR == OFS_BSR)
		begin
			rd_val[3:0] = bsr_reg;
		end
		else if (S_AXI_ARADDR == OFS_FLAGS)
		begin
			rd_val[FLAGS_CARRY_BIT] = carry_reg;
		end
		else if (S_AXI_ARADDR == OFS_FSR2)
		begin
			rd_val[MEM_ADDR_W-1:0] = fsr2_reg;
		end
		else if (S_AXI_ARADDR == OFS_DADDR)
		begin
			rd_val[MEM_ADDR_W-1:0] = daddr_reg;
		end
		else if (S_AXI_ARADDR == OFS_DATA)
		begin
			rd_val[7:0] = (state_reg == ST_IDLE) ? mem_rdata : 8'h00;
		end
		else
		begin
			rd_err = 1'h1;
		end
	end

	always_ff @(posedge CLK)
	begin
		if (!NRST)
		begin
			S_AXI_ARREADY <= 1'h1;
			S_AXI_RVALID <= 1'h0;
			S_AXI_RDATA <= 32'h00000000;
			S_AXI_RRESP <= RESP_OKAY;
		end
		else if (S_AXI_ARVALID && S_AXI_ARREADY)
		begin
			S_AXI_ARREADY <= 1'h0;
			S_AXI_RVALID <= 1'h1;
			S_AXI_RDATA <= rd_val;
			S_AXI_RRESP <= rd_err ? RESP_SLVERR : RESP_OKAY;
		end
		else if (S_AXI_RVALID && S_AXI_RREADY)
		begin
			S_AXI_RVALID <= 1'h0;
			S_AXI_ARREADY <= 1'h1;
		end
	end
endmodule // dsb_exec
`default_nettype wire

/* File: verif/dsb_exec_monitor.sv */
// Bus protocol checker for the execution block, bound to its top module.
`timescale 1ns/10ps
`default_nettype none
module dsb_exec_monitor
	import dsb_pkg::*;
(
	input wire logic CLK,
	input wire logic NRST,
	input wire logic S_AXI_AWVALID,
	input wire logic S_AXI_AWREADY,
	input wire logic S_AXI_WVALID,
	input wire logic S_AXI_WREADY,
	input wire logic [1:0] S_AXI_BRESP,
	input wire logic S_AXI_BVALID,
	input wire logic S_AXI_BREADY,
	input wire logic S_AXI_ARVALID,
	input wire logic S_AXI_ARREADY,
	input wire logic [dsb_pkg::AXI_DW-1:0] S_AXI_RDATA,
	input wire logic S_AXI_RVALID,
	input wire logic S_AXI_RREADY
);
	default clocking cb @(posedge CLK);
	endclocking
	default disable iff (!NRST);
	sequence s_wr_taken;
		S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY;
	endsequence
	sequence s_b_done;
		S_AXI_BVALID && S_AXI_BREADY;
	endsequence
	a_write_answer: assert property (s_wr_taken |-> ##[1:2] S_AXI_BVALID)
		else $error("write response late");
	a_aw_blocked: assert property (S_AXI_AWVALID && S_AXI_AWREADY |=> !S_AXI_AWREADY)
		else $error("write address accepted twice");
	a_b_hold: assert property (S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID && $stable(S_AXI_BRESP))
		else $error("write response dropped");
	a_b_release: assert property (s_b_done |=> !S_AXI_BVALID && S_AXI_AWREADY && S_AXI_WREADY)
		else $error("write channel not released");
	a_bresp_code: assert property (S_AXI_BVALID |-> S_AXI_BRESP == RESP_OKAY || S_AXI_BRESP == RESP_SLVERR)
		else $error("write response code bad");
	a_read_answer: assert property (S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID && !S_AXI_ARREADY)
		else $error("read answer late");
	a_r_hold: assert property (S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID && $stable(S_AXI_RDATA))
		else $error("read data dropped");
	a_r_release: assert property (S_AXI_RVALID && S_AXI_RREADY |=> !S_AXI_RVALID && S_AXI_ARREADY)
		else $error("read channel not released");
endmodule // dsb_exec_monitor
bind dsb_exec dsb_exec_monitor u_dsb_exec_monitor (.*);
`default_nettype wire

/* File: verif/tb.sv */
// Register level test of branch on carry and decrement with skip.
`timescale 1ns/10ps
`default_nettype none
module tb;
	import dsb_pkg::*;
	logic clk, nrst, awv, awr, wv, wr, bv, br, arv, arr, rv, rr;
	logic [AXI_AW-1:0] awa, ara;
	logic [AXI_DW-1:0] wd, rdat, v;
	logic [3:0] ws;
	logic [1:0] bresp, rresp, lr;
	int miscompares = 0;
	int checks_done = 0;
	dsb_exec u_dsb_exec (.CLK(clk), .NRST(nrst), .S_AXI_AWADDR(awa), .S_AXI_AWVALID(awv),
		.S_AXI_AWREADY(awr), .S_AXI_WDATA(wd), .S_AXI_WSTRB(ws), .S_AXI_WVALID(wv),
		.S_AXI_WREADY(wr), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bv), .S_AXI_BREADY(br),
		.S_AXI_ARADDR(ara), .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arr), .S_AXI_RDATA(rdat),
		.S_AXI_RRESP(rresp), .S_AXI_RVALID(rv), .S_AXI_RREADY(rr));
	initial
	begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	task complete_run;
		$display("checks %0d miscompares %0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp)
		begin
			miscompares++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	// Both write channels are offered together and released as each is taken.
	task wreg(input logic [7:0] a, input logic [31:0] d);
		bit done;
		done = 0;
		awa <= a;
		wd <= d;
		awv <= 1'b1;
		wv <= 1'b1;
		br <= 1'b1;
		while (!done)
		begin
			@(posedge clk);
			if (awv && awr)
				awv <= 1'b0;
			if (wv && wr)
				wv <= 1'b0;
			if (bv)
			begin
				lr = bresp;
				br <= 1'b0;
				done = 1;
			end
		end
		@(posedge clk);
	endtask
	task rreg(input logic [7:0] a, output logic [31:0] d);
		bit done;
		done = 0;
		ara <= a;
		arv <= 1'b1;
		rr <= 1'b1;
		while (!done)
		begin
			@(posedge clk);
			if (arv && arr)
				arv <= 1'b0;
			if (rv)
			begin
				d = rdat;
				lr = rresp;
				rr <= 1'b0;
				done = 1;
			end
		end
		@(posedge clk);
	endtask
	// Starts one instruction, waits until busy falls, then checks status and program counter.
	task run(input logic [31:0] i, input logic [31:0] st, input logic [31:0] pc);
		wreg(OFS_INSTR, i);
		do
			rreg(OFS_STATUS, v);
		while (v[0] !== 1'b0);
		chk(v, st);
		rreg(OFS_PC, v);
		chk(v, pc);
	endtask
	initial
	begin
		repeat (20000) @(posedge clk);
		miscompares++;
		complete_run;
	end
	initial
	begin
		{nrst, awv, wv, br, arv, rr} = 6'h00;
		awa = 8'h00;
		ara = 8'h00;
		wd = 32'h0;
		ws = 4'hF;
		repeat (5) @(posedge clk);
		nrst <= 1'b1;
		@(posedge clk);
		wreg(OFS_FLAGS, 32'h1);
		wreg(OFS_PC, 32'h100);
		run(32'hE205, 32'h24, 32'h10C);
		run(32'hE280, 32'h24, 32'h00E);
		rreg(OFS_FLAGS, v);
		chk(v, 32'h1);
		wreg(OFS_FLAGS, 32'h0);
		run(32'hE27F, 32'h10, 32'h010);
		wreg(OFS_BSR, 32'h2);
		wreg(OFS_DADDR, 32'h205);
		wreg(OFS_DATA, 32'h1);
		run(32'h2F05, 32'h22, 32'h014);
		rreg(OFS_DATA, v);
		chk(v, 32'h0);
		run(32'h2F05, 32'h10, 32'h016);
		run(32'h14D05, 32'h32, 32'h01C);
		rreg(OFS_WREG, v);
		chk(v, 32'hFE);
		rreg(OFS_DATA, v);
		chk(v, 32'hFF);
		wreg(OFS_DATA, 32'h1);
		run(32'h4D05, 32'h10, 32'h01E);
		wreg(OFS_CTRL, 32'h1);
		wreg(OFS_FSR2, 32'h300);
		wreg(OFS_DADDR, 32'h310);
		wreg(OFS_DATA, 32'h5);
		run(32'h2E10, 32'h10, 32'h020);
		rreg(OFS_DATA, v);
		chk(v, 32'h4);
		wreg(OFS_DADDR, 32'h35F);
		wreg(OFS_DATA, 32'h1);
		run(32'h2E5F, 32'h22, 32'h024);
		rreg(OFS_DATA, v);
		chk(v, 32'h0);
		// Just above the indexed window the low half of the access bank is used.
		wreg(OFS_DADDR, 32'h060);
		wreg(OFS_DATA, 32'h3);
		chk({30'h0, lr}, {30'h0, RESP_OKAY});
		run(32'h2E60, 32'h10, 32'h026);
		rreg(OFS_DATA, v);
		chk(v, 32'h2);
		wreg(OFS_DADDR, 32'hF85);
		wreg(OFS_DATA, 32'h1);
		run(32'h2E85, 32'h22, 32'h02A);
		rreg(OFS_DATA, v);
		chk(v, 32'h0);
		run(32'h0000, 32'h18, 32'h02C);
		wreg(8'h40, 32'h1);
		chk({30'h0, lr}, {30'h0, RESP_SLVERR});
		rreg(8'h40, v);
		chk(v, 32'h0);
		chk({30'h0, lr}, {30'h0, RESP_SLVERR});
		// A reset between instructions must bring the machine state back to zero.
		nrst <= 1'b0;
		repeat (2) @(posedge clk);
		nrst <= 1'b1;
		@(posedge clk);
		rreg(OFS_PC, v);
		chk(v, 32'h0);
		rreg(OFS_CTRL, v);
		chk(v, 32'h0);
		rreg(OFS_STATUS, v);
		chk(v, 32'h0);
		complete_run;
	end
endmodule // tb
`default_nettype wire
